// [pkg/ct_pkg.sv]
// constants and types of the compact timer
package ct_pkg;

  // widths
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int CMPP_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA = 8'h0C;
  localparam logic [7:0] OFS_CMPP = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // field positions
  localparam int BIT_ON = 3;
  localparam int BIT_FA = 0;
  localparam int BIT_FP = 1;

  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // mode select encodings
  localparam logic [1:0] MODE_CM = 2'b00;
  localparam logic [1:0] MODE_PWM = 2'b10;
  localparam logic [1:0] MODE_TC = 2'b11;

  // pin action encodings, compare match mode
  localparam logic [1:0] ACT_NONE = 2'b00;
  localparam logic [1:0] ACT_LOW = 2'b01;
  localparam logic [1:0] ACT_HIGH = 2'b10;
  localparam logic [1:0] ACT_TOG = 2'b11;

  // pin action encodings, pwm mode
  localparam logic [1:0] PWM_INACT = 2'b00;
  localparam logic [1:0] PWM_ACT = 2'b01;
  localparam logic [1:0] PWM_RUN = 2'b10;

  // compare P is the top byte; the low byte of its target
  localparam logic [7:0] P_LOW = 8'h00;
  // duty of 65536 clocks when compare P is zero
  localparam logic [16:0] DUTY_FULL = 17'h1_0000;

  // control one layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode;     // mode_select_high / mode_select_low
    logic [1:0] action;   // pin_action_high / pin_action_low
    logic ils;            // initial_level_select
    logic inv;            // output_invert
    logic swap;           // duty_period_swap
    logic clr_sel;        // clear_source_select
  } ct_ctrl_s;

endpackage : ct_pkg

// [hdl/ct_timer.sv]
// compact 16-bit timer: compare match, timer/counter and pwm modes
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ct_timer
(
  // apb clock
  input wire logic pclk,
  // asynchronous reset, active low
  input wire logic presetn,
  // apb select
  input wire logic psel,
  // apb access phase
  input wire logic penable,
  // apb direction, high for write
  input wire logic pwrite,
  // apb byte address
  input wire logic [ct_pkg::ADDR_W-1:0] paddr,
  // apb write data
  input wire logic [31:0] pwdata,
  // apb read data
  output logic [31:0] prdata,
  // apb ready
  output logic pready,
  // apb error on unmapped address
  output logic pslverr,
  // timer output pin level
  output logic pin_out,
  // high while the timer owns the pin
  output logic pin_drive
);

  ////////////////////////////////////////////////////////////////////
  // state

  // control one fields
  ct_pkg::ct_ctrl_s ctrl;
  // counter_on bit and its last value
  logic on;
  logic on_q;
  // running counter
  logic [ct_pkg::CNT_W-1:0] cnt;
  // compare values
  logic [ct_pkg::CNT_W-1:0] cmp_a;
  logic [ct_pkg::CMPP_W-1:0] cmp_p;
  // sticky match flags
  logic flag_a;
  logic flag_p;
  // compare match mode pin level before inversion
  logic cm_level;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // count value one clock before the target is reached
  function automatic logic [15:0] ct_last(input logic [15:0] tgt);
    ct_last = tgt - 16'h0001;
  endfunction : ct_last

  // true when the address names a register
  function automatic logic ct_mapped(input logic [7:0] a);
    ct_mapped = (a == ct_pkg::OFS_CTRL0) || (a == ct_pkg::OFS_CTRL1) ||
                (a == ct_pkg::OFS_COUNT) || (a == ct_pkg::OFS_CMPA) ||
                (a == ct_pkg::OFS_CMPP) || (a == ct_pkg::OFS_FLAGS);
  endfunction : ct_mapped

  ////////////////////////////////////////////////////////////////////
  // decode

  // bus phases
  logic setup;
  logic wr;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;

  // counter_on edge and run state
  logic rise;
  logic run;
  assign rise = on & ~on_q;
  assign run = on & on_q;

  // mode decode
  logic is_pwm;
  logic is_cm;
  assign is_pwm = (ctrl.mode == ct_pkg::MODE_PWM);
  assign is_cm = (ctrl.mode == ct_pkg::MODE_CM);

  // comparator A: full 16 bits, zero never matches
  logic a_hit;
  assign a_hit = run && (cmp_a != ct_pkg::CNT_RST) &&
                 (cnt == ct_last(cmp_a));

  // comparator P: top byte only, zero wraps at the overflow
  logic p_hit;
  assign p_hit = run && (cnt == ct_last({cmp_p, ct_pkg::P_LOW}));

  // clear source
  logic clr;
  always_comb
  begin
    if (is_pwm)
    begin
      // swap picks the period register
      clr = ctrl.swap ? a_hit : p_hit;
    end
    else if (ctrl.clr_sel)
    begin
      // clear on A, overflow when A is zero
      clr = a_hit;
    end
    else
    begin
      // clear on P, overflow when P is zero
      clr = p_hit;
    end
  end

  // flag set terms
  logic set_fa;
  logic set_fp;
  assign set_fa = a_hit;
  assign set_fp = p_hit & (is_pwm | ~ctrl.clr_sel);

  // flag clear terms, write one to clear
  logic clr_fa;
  logic clr_fp;
  assign clr_fa = wr && (paddr == ct_pkg::OFS_FLAGS) && pwdata[ct_pkg::BIT_FA];
  assign clr_fp = wr && (paddr == ct_pkg::OFS_FLAGS) && pwdata[ct_pkg::BIT_FP];

  ////////////////////////////////////////////////////////////////////
  // pwm duty compare

  // duty in clocks, 17 bits for the 65536 case
  logic [16:0] duty;
  always_comb
  begin
    if (ctrl.swap)
    begin
      // duty from P times 256
      duty = (cmp_p == ct_pkg::P_LOW) ? ct_pkg::DUTY_FULL :
             {1'b0, cmp_p, ct_pkg::P_LOW};
    end
    else
    begin
      // duty from A
      duty = {1'b0, cmp_a};
    end
  end

  // active phase; count stays below period so duty >= period is full
  logic pwm_on;
  assign pwm_on = ({1'b0, cnt} < duty);

  ////////////////////////////////////////////////////////////////////
  // register writes

  // control, compare and counter_on registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= ct_pkg::CTRL_RST;
      on <= 1'b0;
      cmp_a <= ct_pkg::CNT_RST;
      cmp_p <= ct_pkg::P_LOW;
    end
    else if (wr)
    begin
      // one register per address
      case (paddr)
        ct_pkg::OFS_CTRL0: on <= pwdata[ct_pkg::BIT_ON];
        ct_pkg::OFS_CTRL1: ctrl <= pwdata[7:0];
        ct_pkg::OFS_CMPA: cmp_a <= pwdata[15:0];
        ct_pkg::OFS_CMPP: cmp_p <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // previous counter_on for edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_q <= 1'b0;
    end
    else
    begin
      on_q <= on;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter

  // cleared on rise, held while off, counts in every mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= ct_pkg::CNT_RST;
    end
    else if (rise)
    begin
      // restart from zero
      cnt <= ct_pkg::CNT_RST;
    end
    else if (run)
    begin
      // wraps naturally at FFFF
      cnt <= clr ? ct_pkg::CNT_RST : cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // match flags

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end
    else
    begin
      flag_a <= set_fa | (flag_a & ~clr_fa);
      flag_p <= set_fp | (flag_p & ~clr_fp);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compare match pin level

  // moves on A match only, restored on counter_on rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cm_level <= 1'b0;
    end
    else if (rise)
    begin
      // initial level
      cm_level <= ctrl.ils;
    end
    else if (a_hit && !is_pwm)
    begin
      // P matches never reach here
      case (ctrl.action)
        ct_pkg::ACT_NONE: cm_level <= cm_level;
        ct_pkg::ACT_LOW: cm_level <= 1'b0;
        ct_pkg::ACT_HIGH: cm_level <= 1'b1;
        ct_pkg::ACT_TOG: cm_level <= ~cm_level;
        default: cm_level <= cm_level;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output pin

  // next pin level and ownership
  logic next_pin;
  logic next_drive;
  logic lvl;
  always_comb
  begin
    lvl = 1'b0;
    next_pin = 1'b0;
    next_drive = 1'b0;
    case (ctrl.mode)
      ct_pkg::MODE_CM:
      begin
        // compare level, then inversion
        next_pin = cm_level ^ ctrl.inv;
        next_drive = 1'b1;
      end
      ct_pkg::MODE_PWM:
      begin
        // ils is the active level
        case (ctrl.action)
          ct_pkg::PWM_INACT: lvl = ~ctrl.ils;
          ct_pkg::PWM_ACT: lvl = ctrl.ils;
          ct_pkg::PWM_RUN: lvl = pwm_on ? ctrl.ils : ~ctrl.ils;
          default: lvl = ~ctrl.ils;
        endcase
        next_pin = lvl ^ ctrl.inv;
        next_drive = 1'b1;
      end
      default:
      begin
        // timer/counter and undefined mode release the pin
        next_pin = 1'b0;
        next_drive = 1'b0;
      end
    endcase
  end

  // pin flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_drive <= 1'b0;
    end
    else
    begin
      pin_out <= next_pin;
      pin_drive <= next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb read and response

  // read mux
  logic [31:0] rd;
  always_comb
  begin
    rd = ct_pkg::WORD_ZERO;
    case (paddr)
      ct_pkg::OFS_CTRL0: rd[ct_pkg::BIT_ON] = on;
      ct_pkg::OFS_CTRL1: rd[7:0] = ctrl;
      ct_pkg::OFS_COUNT: rd[15:0] = cnt;
      ct_pkg::OFS_CMPA: rd[15:0] = cmp_a;
      ct_pkg::OFS_CMPP: rd[7:0] = cmp_p;
      ct_pkg::OFS_FLAGS:
      begin
        rd[ct_pkg::BIT_FA] = flag_a;
        rd[ct_pkg::BIT_FP] = flag_p;
      end
      default: rd = ct_pkg::WORD_ZERO;
    endcase
  end

  // answer in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= ct_pkg::WORD_ZERO;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~ct_mapped(paddr);
      prdata <= setup ? rd : ct_pkg::WORD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // counter_on rising edge
  sequence s_on_rise;
    on && !on_q;
  endsequence

  // compare mode counter at its P target with clear low
  sequence s_p_clear;
    run && is_cm && !ctrl.clr_sel && p_hit;
  endsequence

  a_rise_zero_cnt: assert property (s_on_rise |=> cnt == ct_pkg::CNT_RST)
    else $error("counter not cleared on counter_on rise");
  a_off_hold_cnt: assert property (!on && !on_q |=> $stable(cnt))
    else $error("counter moved while stopped");
  a_p_match_clr: assert property (s_p_clear ##0 on |=> cnt == ct_pkg::CNT_RST)
    else $error("P match did not clear counter");
  a_no_p_flag: assert property (!is_pwm && ctrl.clr_sel && !flag_p |=> !flag_p)
    else $error("match P flag raised with clear select high");
  a_a_zero_noflag: assert property (cmp_a == ct_pkg::CNT_RST && !flag_a |=> !flag_a)
    else $error("match A flag raised with compare A zero");
  a_pin_only_a: assert property (is_cm && !rise && !a_hit |=> $stable(cm_level))
    else $error("pin level moved without A match");
  a_rise_init_pin: assert property (s_on_rise |=> cm_level == $past(ctrl.ils))
    else $error("pin not restored to initial level");
  a_flag_sticky: assert property (flag_a && !clr_fa |=> flag_a)
    else $error("match A flag dropped without clear");
  a_tc_release: assert property (ctrl.mode == ct_pkg::MODE_TC |=> !pin_drive)
    else $error("pin driven in timer/counter mode");
  a_pwm_full: assert property
    (is_pwm && !ctrl.swap && ctrl.action == ct_pkg::PWM_RUN && run &&
     cmp_p != ct_pkg::P_LOW && cmp_a >= {cmp_p, ct_pkg::P_LOW}
     |=> pin_out == ($past(ctrl.ils) ^ $past(ctrl.inv)))
    else $error("pwm not at full duty");
  a_set_wins: assert property (set_fp |=> flag_p)
    else $error("match P flag lost");
endmodule : ct_timer

// [sim/testbench.sv]
// self-checking testbench of the compact timer over apb
`timescale 1ns/1ps
module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ct_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_out;
  logic pin_drive;
  // result counters
  int n_errors;
  int check_count;
  // last read data and error
  logic [31:0] rd;
  logic [31:0] rd_prev;
  logic err;

  ct_timer i_ct_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pin_out(pin_out),
    .pin_drive(pin_drive)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 25 ns period
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // compare a word
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // compare a single bit
  task chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one apb transfer, waits for ready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t no ready", $time);
      complete_run();
    end
  endtask : apb

  // register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // register read and compare
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd, exp);
  endtask : rdc

  // let cycles pass
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // stop, configure, clear flags, restart
  task setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wr(ct_pkg::OFS_CTRL0, 32'h0000_0000);
    wr(ct_pkg::OFS_CTRL1, {24'h00_0000, c1});
    wr(ct_pkg::OFS_CMPA, {16'h0000, a});
    wr(ct_pkg::OFS_CMPP, {24'h00_0000, p});
    wr(ct_pkg::OFS_FLAGS, 32'h0000_0003);
    wr(ct_pkg::OFS_CTRL0, 32'h0000_0008);
  endtask : setup

  // pwm run: high cycles over a 512-clock window and flags
  task pwm_case(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                input int exp_hi, input logic [31:0] exp_fl);
    int hi;
    setup(c1, a, p);
    idle(300);
    hi = 0;
    repeat (512)
    begin
      @(posedge pclk);
      if (pin_out === 1'b1)
        hi++;
    end
    chk_word(32'(hi), 32'(exp_hi));
    chk_bit(pin_drive, 1'b1);
    rdc(ct_pkg::OFS_FLAGS, exp_fl);
    $display("pwm case %h done", c1);
  endtask : pwm_case

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    n_errors = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped place, read-only counter, widths
    rdc(ct_pkg::OFS_CTRL0, 32'h0000_0000);
    rdc(ct_pkg::OFS_CTRL1, 32'h0000_0000);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0000_0000);
    wr(ct_pkg::OFS_COUNT, 32'h0000_1234);
    rdc(ct_pkg::OFS_COUNT, 32'h0000_0000);
    wr(ct_pkg::OFS_CMPA, 32'hFFFF_ABCD);
    rdc(ct_pkg::OFS_CMPA, 32'h0000_ABCD);
    wr(ct_pkg::OFS_CMPP, 32'h0000_01FF);
    rdc(ct_pkg::OFS_CMPP, 32'h0000_00FF);
    $display("registers done");
    // compare mode, clear on p, drive high on a match
    setup(8'h20, 16'h0040, 8'h01);
    idle(5);
    chk_bit(pin_out, 1'b0);
    chk_bit(pin_drive, 1'b1);
    idle(20);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0000);
    idle(60);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0001);
    chk_bit(pin_out, 1'b1);
    idle(190);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0003);
    apb(1'b0, ct_pkg::OFS_COUNT, 32'h0000_0000);
    chk_bit(rd < 32'h0000_0040, 1'b1);
    wr(ct_pkg::OFS_FLAGS, 32'h0000_0003);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0000);
    // stop holds the count, restart clears it and the pin
    wr(ct_pkg::OFS_CTRL0, 32'h0000_0000);
    apb(1'b0, ct_pkg::OFS_COUNT, 32'h0000_0000);
    rd_prev = rd;
    idle(10);
    rdc(ct_pkg::OFS_COUNT, rd_prev);
    chk_bit(rd_prev != 32'h0000_0000, 1'b1);
    wr(ct_pkg::OFS_CTRL0, 32'h0000_0008);
    idle(3);
    chk_bit(pin_out, 1'b0);
    apb(1'b0, ct_pkg::OFS_COUNT, 32'h0000_0000);
    chk_bit(rd < 32'h0000_0010, 1'b1);
    $display("compare clear p done");
    // compare mode, clear on a, toggle, p below a
    setup(8'h39, 16'h0180, 8'h01);
    idle(3);
    chk_bit(pin_out, 1'b1);
    idle(400);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0001);
    chk_bit(pin_out, 1'b0);
    apb(1'b0, ct_pkg::OFS_COUNT, 32'h0000_0000);
    chk_bit(rd < 32'h0000_0180, 1'b1);
    idle(380);
    chk_bit(pin_out, 1'b1);
    $display("compare clear a done");
    // compare a zero with clear on a: no clear, no flags
    setup(8'h39, 16'h0000, 8'h01);
    idle(500);
    apb(1'b0, ct_pkg::OFS_COUNT, 32'h0000_0000);
    chk_bit(rd > 32'h0000_0180, 1'b1);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0000);
    chk_bit(pin_out, 1'b1);
    $display("overflow done");
    // action low drives the pin low on an A match
    setup(8'h18, 16'h0040, 8'h01);
    idle(3);
    chk_bit(pin_out, 1'b1);
    idle(100);
    chk_bit(pin_out, 1'b0);
    $display("action low done");
    // action none leaves the pin, timer mode frees the pin
    setup(8'h08, 16'h0040, 8'h01);
    idle(100);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0001);
    chk_bit(pin_out, 1'b1);
    setup(8'hE8, 16'h0040, 8'h01);
    idle(100);
    chk_bit(pin_drive, 1'b0);
    rdc(ct_pkg::OFS_FLAGS, 32'h0000_0001);
    $display("action none and timer mode done");
    // pwm table
    pwm_case(8'hA9, 16'h0040, 8'h01, 128, 32'h0000_0003);
    pwm_case(8'hAD, 16'h0040, 8'h01, 384, 32'h0000_0003);
    pwm_case(8'hA1, 16'h0040, 8'h01, 384, 32'h0000_0003);
    pwm_case(8'hAA, 16'h0200, 8'h01, 256, 32'h0000_0003);
    pwm_case(8'hA8, 16'h0200, 8'h01, 512, 32'h0000_0002);
    pwm_case(8'h88, 16'h0040, 8'h01, 0, 32'h0000_0003);
    pwm_case(8'h98, 16'h0040, 8'h01, 512, 32'h0000_0003);
    pwm_case(8'hAA, 16'h0200, 8'h00, 512, 32'h0000_0001);
    complete_run();
  end
endmodule : testbench
